// ==== logic/eic_collector.sv ====
// error interrupt collector: latch, core nmi edge, doorbell pci pins
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module eic_collector (
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_rst,
  input  wire logic                   i_sw_reset,
  // error sources from internal units
  input  wire eic_pkg::eic_bridge_err_t i_pbridge_err,
  input  wire eic_pkg::eic_bridge_err_t i_sbridge_err,
  input  wire eic_pkg::eic_atu_err_t    i_patu_err,
  input  wire eic_pkg::eic_atu_err_t    i_satu_err,
  input  wire eic_pkg::eic_msg_err_t    i_msg_err,
  input  wire logic                   i_biu_ib_abort,
  input  wire eic_pkg::eic_dma_err_t    i_dma0_err,
  input  wire eic_pkg::eic_dma_err_t    i_dma1_err,
  input  wire eic_pkg::eic_dma_err_t    i_dma2_err,
  input  wire logic                   i_accel_ib_abort,
  input  wire logic                   i_memc_ecc_abort,
  // external nmi pin, active low, asynchronous
  input  wire logic                   i_ext_nmi_n,
  // other core latch inputs for status reads
  input  wire logic [31:0]            i_external_int_line_seven_latch,
  input  wire logic [31:0]            i_external_int_line_six_latch,
  // register port
  input  wire logic [3:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [31:0]                 o_rdata,
  // core side
  output logic                        o_core_nmi_n,
  output logic [23:0]                 o_route_select,
  output logic [31:0]                 o_core_mask,
  // primary pci interrupt pins, open drain
  output logic                        o_primary_pci_int_a_n,
  output logic                        o_primary_pci_int_b_n,
  output logic                        o_primary_pci_int_c_n,
  output logic                        o_primary_pci_int_d_n,
  output logic [3:0]                  o_pci_int_oe
);

  // combined reset: pin or software
  logic sw_reset_q;
  logic rst_all;
  assign rst_all = i_rst | sw_reset_q;

  // registered software reset request
  // a flop output keeps glitches off the async reset net
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= i_sw_reset;
    end
  end

  // two-stage synchroniser for the external pin
  // idle level is high so reset makes no false request
  logic ext_meta_q;
  logic ext_sync_q;
  // first stage, read only by the second
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      ext_meta_q <= 1'b1;
    end else begin
      ext_meta_q <= i_ext_nmi_n;
    end
  end

  // second stage, the only reader of the first
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      ext_sync_q <= 1'b1;
    end else begin
      ext_sync_q <= ext_meta_q;
    end
  end

  // software registers
  logic [31:0] src_enable_q;
  logic [31:0] doorbell_q;
  logic [23:0] route_q;
  logic [31:0] mask_q;
  logic [2:0]  pin_sel_q;

  // per-channel dma summary, any of the four conditions
  eic_pkg::eic_dma_err_t dma_err [3];
  logic [2:0]            dma_any;

  assign dma_err[0] = i_dma0_err;
  assign dma_err[1] = i_dma1_err;
  assign dma_err[2] = i_dma2_err;
  // each channel folds its conditions into one latch bit
  for (genvar c = 0; c < 3; c++) begin : g_dma
    assign dma_any[c] = |dma_err[c];
  end

  // raw source vector, one bit per error condition, but one bit per dma channel
  // the secondary unit has no self-test source
  logic [eic_pkg::NUM_SRC-1:0] raw_src;
  always_comb begin
    raw_src = '0;
    raw_src[eic_pkg::B_EXT] = ~ext_sync_q;
    raw_src[eic_pkg::B_PBRIDGE +: 5] = i_pbridge_err;
    raw_src[eic_pkg::B_SBRIDGE +: 5] = i_sbridge_err;
    raw_src[eic_pkg::B_PATU +: 7] = i_patu_err;
    raw_src[eic_pkg::B_SATU +: 6] = i_satu_err[5:0];
    raw_src[eic_pkg::B_MSG +: 2] = i_msg_err;
    raw_src[eic_pkg::B_BIU] = i_biu_ib_abort;
    raw_src[eic_pkg::B_DMA +: 3] = dma_any;
    raw_src[eic_pkg::B_ACCEL] = i_accel_ib_abort;
    raw_src[eic_pkg::B_MEMC] = i_memc_ecc_abort;
  end

  // error latch follows enabled source level
  // no software clear: a bit drops when its source drops
  logic [eic_pkg::NUM_SRC-1:0] latch_q;
  logic [eic_pkg::NUM_SRC-1:0] latch_d;
  assign latch_d = raw_src & src_enable_q;

  // one flop per source
  for (genvar b = 0; b < eic_pkg::NUM_SRC; b++) begin : g_latch
    always_ff @(posedge i_clock or posedge rst_all) begin
      if (rst_all) begin
        latch_q[b] <= eic_pkg::RST_STATUS[b];
      end else begin
        latch_q[b] <= latch_d[b];
      end
    end
  end

  // core nmi edge generator
  // the core input is edge triggered, so a cleared source
  // forces two high cycles before the next low edge
  eic_pkg::eic_nmi_state_t st_q;
  logic any_err;
  logic cleared_one;
  // any latched bit, and any bit dropping this cycle
  assign any_err     = |latch_q;
  assign cleared_one = |(latch_q & ~latch_d);
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      st_q <= eic_pkg::ST_IDLE;
    end else begin
      unique case (st_q)
        eic_pkg::ST_IDLE: begin
          if (any_err) begin
            st_q <= eic_pkg::ST_LOW;
          end
        end
        eic_pkg::ST_LOW: begin
          if (!any_err) begin
            st_q <= eic_pkg::ST_IDLE;
          end else if (cleared_one) begin
            st_q <= eic_pkg::ST_REARM;
          end
        end
        eic_pkg::ST_REARM: begin
          st_q <= eic_pkg::ST_IDLE;
        end
        default: st_q <= eic_pkg::ST_IDLE;
      endcase
    end
  end
  assign o_core_nmi_n = (st_q != eic_pkg::ST_LOW);

  // write decode, one strobe per register; status is read only
  logic wr_doorbell;
  logic wr_route;
  logic wr_mask;
  logic wr_pin_sel;
  logic wr_src_en;

  assign wr_doorbell = i_wr && (i_addr == eic_pkg::ADDR_DOORBELL);
  assign wr_route    = i_wr && (i_addr == eic_pkg::ADDR_ROUTE_SELECT);
  assign wr_mask     = i_wr && (i_addr == eic_pkg::ADDR_CORE_MASK);
  assign wr_pin_sel  = i_wr && (i_addr == eic_pkg::ADDR_PIN_SELECT);
  assign wr_src_en   = i_wr && (i_addr == eic_pkg::ADDR_SRC_ENABLE);

  // outbound doorbell register
  // low bits all share the one selected pin
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      doorbell_q <= eic_pkg::RST_DOORBELL;
    end else if (wr_doorbell) begin
      doorbell_q <= i_wdata;
    end
  end

  // routing select register
  // zero sends every request to the core
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      route_q <= eic_pkg::RST_ROUTE_SELECT;
    end else if (wr_route) begin
      route_q <= i_wdata[23:0];
    end
  end

  // core mask register
  // zero masks every interrupt after reset
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      mask_q <= eic_pkg::RST_CORE_MASK;
    end else if (wr_mask) begin
      mask_q <= i_wdata;
    end
  end

  // pin select field, picks the pin for low doorbell bits
  // codes other than one to four drive no pin
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      pin_sel_q <= eic_pkg::RST_PIN_SELECT;
    end else if (wr_pin_sel) begin
      pin_sel_q <= i_wdata[2:0];
    end
  end

  // source enable register
  // all ones so every source counts after reset
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      src_enable_q <= eic_pkg::RST_SRC_ENABLE;
    end else if (wr_src_en) begin
      src_enable_q <= i_wdata;
    end
  end

  // routing and mask drive the core side from their flops
  assign o_route_select = route_q;
  assign o_core_mask    = mask_q;

  // external_int_line_seven and external_int_line_six status, captured so they reset cleared
  // the capture adds one cycle of age to these views
  logic [31:0] external_int_line_seven_q;
  logic [31:0] external_int_line_six_q;
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      external_int_line_seven_q <= eic_pkg::RST_STATUS;
      external_int_line_six_q <= eic_pkg::RST_STATUS;
    end else begin
      external_int_line_seven_q <= i_external_int_line_seven_latch;
      external_int_line_six_q <= i_external_int_line_six_latch;
    end
  end

  // read mux, zero for unmapped indices
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_addr)
      eic_pkg::ADDR_ERR_STATUS:   rd_mux = latch_q;
      eic_pkg::ADDR_DOORBELL:     rd_mux = doorbell_q;
      eic_pkg::ADDR_ROUTE_SELECT: rd_mux = {8'h00, route_q};
      eic_pkg::ADDR_CORE_MASK:    rd_mux = mask_q;
      eic_pkg::ADDR_PIN_SELECT:   rd_mux = {29'h0, pin_sel_q};
      eic_pkg::ADDR_SRC_ENABLE:   rd_mux = src_enable_q;
      eic_pkg::ADDR_EXTERNAL_INT_LINE_SEVEN_STATUS: rd_mux = external_int_line_seven_q;
      eic_pkg::ADDR_EXTERNAL_INT_LINE_SIX_STATUS: rd_mux = external_int_line_six_q;
      default:                    rd_mux = 32'h0000_0000;
    endcase
  end

  // read data register, valid only in the cycle after the strobe
  // one cycle only, so a stale word is never taken twice
  always_ff @(posedge i_clock or posedge rst_all) begin
    if (rst_all) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // doorbell to pci pins
  // pins a to d map to enable bits 0 to 3
  logic       low_any;
  logic [3:0] low_pin;
  logic [3:0] pin_req;
  logic [3:0] pin_q;
  // any low doorbell bit raises the selected pin
  assign low_any = |doorbell_q[eic_pkg::DB_LOW_MSB:0];
  always_comb begin
    low_pin = 4'h0;
    unique case (pin_sel_q)
      3'h1:    low_pin = 4'h1;
      3'h2:    low_pin = 4'h2;
      3'h3:    low_pin = 4'h4;
      3'h4:    low_pin = 4'h8;
      default: low_pin = 4'h0;
    endcase
  end
  // high bits map straight onto pins a to d
  assign pin_req = doorbell_q[eic_pkg::DB_INTA_BIT +: 4] | (low_any ? low_pin : 4'h0);

  // one open-drain enable flop per pin
  for (genvar p = 0; p < 4; p++) begin : g_pin
    always_ff @(posedge i_clock or posedge rst_all) begin
      if (rst_all) begin
        pin_q[p] <= 1'b0;
      end else begin
        pin_q[p] <= pin_req[p];
      end
    end
  end

  // open drain: data stays low, the enable does the driving
  assign o_primary_pci_int_a_n = 1'b0;
  assign o_primary_pci_int_b_n = 1'b0;
  assign o_primary_pci_int_c_n = 1'b0;
  assign o_primary_pci_int_d_n = 1'b0;
  assign o_pci_int_oe = pin_q; // drive low only when asserted

endmodule // eic_collector
`default_nettype wire

// ==== pkg/eic_pkg.sv ====
// package for the error interrupt collector: offsets, layouts, reset values
`default_nettype none
package eic_pkg;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_ERR_STATUS    = 4'h0;
  localparam logic [3:0] ADDR_DOORBELL      = 4'h1;
  localparam logic [3:0] ADDR_ROUTE_SELECT  = 4'h2;
  localparam logic [3:0] ADDR_CORE_MASK     = 4'h3;
  localparam logic [3:0] ADDR_PIN_SELECT    = 4'h4;
  localparam logic [3:0] ADDR_SRC_ENABLE    = 4'h5;
  localparam logic [3:0] ADDR_EXTERNAL_INT_LINE_SEVEN_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_EXTERNAL_INT_LINE_SIX_STATUS  = 4'h7;
  // reset values
  localparam logic [31:0] RST_DOORBELL      = 32'h0000_0000;
  localparam logic [23:0] RST_ROUTE_SELECT  = 24'h00_0000;
  localparam logic [31:0] RST_CORE_MASK     = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS        = 32'h0000_0000;
  localparam logic [2:0]  RST_PIN_SELECT    = 3'h1;
  localparam logic [31:0] RST_SRC_ENABLE    = 32'hffff_ffff;
  // doorbell field positions
  localparam int DB_INTA_BIT  = 28;
  localparam int DB_LOW_MSB   = 27;
  // error latch layout: number of sources
  localparam int NUM_SRC = 32;
  // latch bit positions
  localparam int B_EXT     = 0;
  localparam int B_PBRIDGE = 1;   // 5 bits
  localparam int B_SBRIDGE = 6;   // 5 bits
  localparam int B_PATU    = 11;  // 7 bits
  localparam int B_SATU    = 18;  // 6 bits
  localparam int B_MSG     = 24;  // 2 bits
  localparam int B_BIU     = 26;
  localparam int B_DMA     = 27;  // 3 bits, one per channel
  localparam int B_ACCEL   = 30;
  localparam int B_MEMC    = 31;
  // bridge error bundle
  typedef struct packed {
    logic serr;
    logic master_abort;
    logic tabort_master;
    logic tabort_target;
    logic master_parity;
  } eic_bridge_err_t;
  // translation unit error bundle
  typedef struct packed {
    logic bist;
    logic ib_master_abort;
    logic serr_detected;
    logic master_abort;
    logic tabort_master;
    logic tabort_target;
    logic master_parity;
  } eic_atu_err_t;
  // dma channel error bundle
  typedef struct packed {
    logic ib_master_abort;
    logic master_abort;
    logic tabort_master;
    logic master_parity;
  } eic_dma_err_t;
  // messaging unit error bundle
  typedef struct packed {
    logic nmi_doorbell;
    logic free_queue_full;
  } eic_msg_err_t;
  // core-edge state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LOW   = 3'b010,
    ST_REARM = 3'b100
  } eic_nmi_state_t;
endpackage : eic_pkg
`default_nettype wire

// ==== tb/eic_collector_assertions.sv ====
// port checker for the error interrupt collector
`timescale 1ns/1ps
`default_nettype none
module eic_collector_assertions (
  // clock and resets
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_sw_reset,
  // watched sources
  input wire logic        i_accel_ib_abort,
  input wire logic        i_memc_ecc_abort,
  // register port
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // outputs
  input wire logic        o_core_nmi_n,
  input wire logic [23:0] o_route_select,
  input wire logic [31:0] o_core_mask,
  input wire logic [3:0]  o_pci_int_oe
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // register port timing and reset values
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
  property p_unmapped;
    i_rd && i_addr > 4'h7 |=> o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_vals;
    $fell(i_rst) |-> !o_route_select && !o_core_mask && !o_pci_int_oe && o_core_nmi_n;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
  property p_route_wr;
    i_wr && i_addr == eic_pkg::ADDR_ROUTE_SELECT && !i_sw_reset && !$past(i_sw_reset)
      |=> o_route_select == $past(i_wdata[23:0]);
  endproperty
  a_route_wr: assert property (p_route_wr) else $error("route select not taken");
  property p_mask_wr;
    i_wr && i_addr == eic_pkg::ADDR_CORE_MASK && !i_sw_reset && !$past(i_sw_reset)
      |=> o_core_mask == $past(i_wdata);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("core mask not taken");
  property p_doorbell;
    i_wr && i_addr == eic_pkg::ADDR_DOORBELL && !i_wdata[27:0]
      ##1 !(i_wr && i_addr == eic_pkg::ADDR_DOORBELL) |=> o_pci_int_oe == $past(i_wdata[31:28], 2);
  endproperty
  a_doorbell: assert property (p_doorbell) else $error("doorbell pins wrong");
  // core edge while sources stay and after one clears
  property p_both_low;
    (i_memc_ecc_abort && i_accel_ib_abort) [*4] |-> !o_core_nmi_n;
  endproperty
  a_both_low: assert property (p_both_low) else $error("core request not low");
  property p_rearm;
    (i_memc_ecc_abort && i_accel_ib_abort) [*4] ##1 (i_memc_ecc_abort && !i_accel_ib_abort)
      |-> ##[0:4] o_core_nmi_n ##[1:4] !o_core_nmi_n;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no fresh core edge");
endmodule  // eic_collector_assertions
bind eic_collector eic_collector_assertions u_chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_sw_reset(i_sw_reset), .i_accel_ib_abort(i_accel_ib_abort), .i_addr(i_addr),
  .i_memc_ecc_abort(i_memc_ecc_abort), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_core_nmi_n(o_core_nmi_n), .o_route_select(o_route_select),
  .o_core_mask(o_core_mask), .o_pci_int_oe(o_pci_int_oe));
`default_nettype wire

// ==== tb/eic_collector_tb.sv ====
// self-checking bench for the error interrupt collector
`timescale 1ns/1ps
`default_nettype none
module eic_collector_tb;
  logic        i_clock, i_rst, i_sw_reset, i_wr, i_rd, ext_n, nmi_n, bist, seen;
  logic [1:0]  pick;
  logic [2:0]  ps;
  logic [3:0]  i_addr, oe, pin_n;
  logic [11:0] dma;
  logic [23:0] route;
  logic [31:0] cond, i_wdata, o_rdata, x7, x6, mask, v, db;
  int          err_total = 0;
  int          cmp_count = 0;
  // peripheral model and design
  eic_periph_model u_per (.i_cond(cond), .i_pick(pick), .o_dma(dma), .o_ext_nmi_n(ext_n),
    .o_bist(bist));
  eic_collector dut (.i_clock(i_clock), .i_rst(i_rst), .i_sw_reset(i_sw_reset),
    .i_pbridge_err(cond[5:1]), .i_sbridge_err(cond[10:6]), .i_patu_err(cond[17:11]),
    .i_satu_err({bist, cond[23:18]}), .i_msg_err(cond[25:24]), .i_biu_ib_abort(cond[26]),
    .i_dma0_err(dma[3:0]), .i_dma1_err(dma[7:4]), .i_dma2_err(dma[11:8]),
    .i_accel_ib_abort(cond[30]), .i_memc_ecc_abort(cond[31]), .i_ext_nmi_n(ext_n),
    .i_external_int_line_seven_latch(x7), .i_external_int_line_six_latch(x6), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_core_nmi_n(nmi_n),
    .o_route_select(route), .o_core_mask(mask), .o_primary_pci_int_a_n(pin_n[0]),
    .o_primary_pci_int_b_n(pin_n[1]), .o_primary_pci_int_c_n(pin_n[2]),
    .o_primary_pci_int_d_n(pin_n[3]),
    .o_pci_int_oe(oe));
  // clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // shared checks and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata, exp);
    @(posedge i_clock);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expected reset reads and pin enables
  function automatic logic [31:0] rst_val(input int a);
    case (a)
      4: return {29'h0, eic_pkg::RST_PIN_SELECT};
      5: return eic_pkg::RST_SRC_ENABLE;
      6: return x7;
      7: return x6;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [3:0] oe_exp(input logic [31:0] d, input logic [2:0] p);
    oe_exp = d[31:28];
    if (d[27:0] != 28'h0 && p >= 3'h1 && p <= 3'h4) oe_exp[p - 3'h1] = 1'b1;
  endfunction
  // watchdog
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    i_rst = 1'b1;
    {i_sw_reset, i_wr, i_rd, pick, i_addr, i_wdata, cond} = '0;
    void'($urandom(53499));
    x7 = $urandom;
    x6 = $urandom;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    for (int a = 0; a < 9; a++) rdc(a[3:0], rst_val(a));
    // each source alone, then random mixes
    for (int i = 0; i < 52; i++) begin
      v = (i < 32) ? 32'h1 << i : $urandom | 32'h1;
      cond <= v;
      pick <= 2'($urandom);
      repeat (5) @(posedge i_clock);
      rdc(eic_pkg::ADDR_ERR_STATUS, v);
      chk({31'h0, nmi_n}, 32'h0);
      wr(eic_pkg::ADDR_ERR_STATUS, 32'h0);
      rdc(eic_pkg::ADDR_ERR_STATUS, v);
      cond <= 32'h0;
      repeat (5) @(posedge i_clock);
      rdc(eic_pkg::ADDR_ERR_STATUS, 32'h0);
      chk({31'h0, nmi_n}, 32'h1);
    end
    // one of two sources clears
    cond <= 32'hc000_0000;
    repeat (6) @(posedge i_clock);
    cond <= 32'h8000_0000;
    seen = 1'b0;
    repeat (6) begin
      @(negedge i_clock);
      seen = seen | nmi_n;
    end
    chk({30'h0, seen, nmi_n}, 32'h2);
    @(posedge i_clock);
    cond <= 32'h0;
    // doorbell pins, pin select codes zero to four
    for (int k = 0; k < 9; k++) begin
      ps = (k < 4) ? 3'h1 : 3'(k - 4);
      db = (k < 4) ? 32'h1 << (28 + k) : 32'h1 << ($urandom % 28);
      wr(eic_pkg::ADDR_PIN_SELECT, {29'h0, ps});
      wr(eic_pkg::ADDR_DOORBELL, db);
      repeat (3) @(posedge i_clock);
      chk({28'h0, oe}, {28'h0, oe_exp(db, ps)});
      chk({28'h0, pin_n}, 32'h0);
      rdc(eic_pkg::ADDR_DOORBELL, db);
    end
    // routing and mask, then software reset
    v = $urandom;
    wr(eic_pkg::ADDR_ROUTE_SELECT, v);
    wr(eic_pkg::ADDR_CORE_MASK, ~v);
    rdc(eic_pkg::ADDR_ROUTE_SELECT, {8'h0, v[23:0]});
    chk(mask, ~v);
    i_sw_reset <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_sw_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk({route, oe, 4'h0}, 32'h0);
    chk(mask, 32'h0);
    // disabled source stays out of the latch
    wr(eic_pkg::ADDR_SRC_ENABLE, 32'h8000_0000);
    cond <= 32'h8000_0002;
    repeat (5) @(posedge i_clock);
    rdc(eic_pkg::ADDR_ERR_STATUS, 32'h8000_0000);
    print_verdict();
  end
endmodule  // eic_collector_tb
`default_nettype wire

// ==== tb/eic_periph_model.sv ====
// peripheral model: dma error fields, external pin, bist noise
`timescale 1ns/1ps
`default_nettype none
module eic_periph_model (
  // condition word in latch order and field pick
  input  wire logic [31:0] i_cond,
  input  wire logic [1:0]  i_pick,
  // dma fields, pin level, bist noise
  output logic      [11:0] o_dma,
  output logic             o_ext_nmi_n,
  output logic             o_bist
);
  // one error field per raised channel
  assign o_dma[3:0]  = i_cond[27] ? 4'h1 << i_pick : 4'h0;
  assign o_dma[7:4]  = i_cond[28] ? 4'h1 << i_pick : 4'h0;
  assign o_dma[11:8] = i_cond[29] ? 4'h1 << i_pick : 4'h0;
  // pin held as a level while the condition lasts
  assign o_ext_nmi_n = ~i_cond[0];
  // secondary bist toggles and must not show
  assign o_bist      = i_pick[0];
endmodule  // eic_periph_model
`default_nettype wire
